// *** rf_slot_pkg.sv ***
`default_nettype none
package rf_slot_pkg;

  // Byte addresses of the register bank on the AXI4-Lite slave.
  localparam logic [31:0] ADDR_RF_TEST_CONTROL  = 32'h4000_00E0;
  localparam logic [31:0] ADDR_RF_TEST_TX_STAT  = 32'h4000_00E4;
  localparam logic [31:0] ADDR_RF_TEST_RX_STAT  = 32'h4000_00E8;
  localparam logic [31:0] ADDR_SLOT_TIME_COUNT  = 32'h4000_00EC;
  localparam logic [31:0] ADDR_TIMING_GEN_CTRL  = 32'h4000_00F0;
  localparam logic [31:0] ADDR_COARSE_TARGET    = 32'h4000_00F4;
  localparam logic [31:0] ADDR_FINE_TARGET      = 32'h4000_00F8;
  localparam logic [31:0] ADDR_BASE_SNAPSHOT    = 32'h4000_00FC;

  // Field positions inside rf_test_control.
  localparam int unsigned POS_ENDLESS_RX      = 31;
  localparam int unsigned POS_RX_COUNT_EN     = 27;
  localparam int unsigned POS_ENDLESS_TX      = 15;
  localparam int unsigned POS_TX_LENGTH_SEL   = 14;
  localparam int unsigned POS_PRBS_SEL        = 13;
  localparam int unsigned POS_TX_PAYLOAD_SEL  = 12;
  localparam int unsigned POS_TX_COUNT_EN     = 11;
  localparam int unsigned TX_LENGTH_MSB       = 8;

  // Field positions inside timing_generator_control and the snapshot register.
  localparam int unsigned POS_PREFETCH_ABORT  = 31;
  localparam int unsigned ABORT_INSTANT_LSB   = 16;
  localparam int unsigned ABORT_INSTANT_MSB   = 25;
  localparam int unsigned FETCH_INSTANT_MSB   = 8;
  localparam int unsigned POS_SNAPSHOT        = 0;

  // Writable bits and reset values of the stored registers.
  localparam logic [31:0] MASK_RF_TEST_CONTROL = 32'h8800_F9FF;
  localparam logic [31:0] MASK_TIMING_GEN_CTRL = 32'h83FF_01FF;
  localparam logic [31:0] MASK_COARSE_TARGET   = 32'h007F_FFFF;
  localparam logic [31:0] MASK_FINE_TARGET     = 32'h07FF_FFFF;
  localparam logic [31:0] RST_RF_TEST_CONTROL  = 32'h0000_0000;
  localparam logic [31:0] RST_TIMING_GEN_CTRL  = 32'h81FE_0096;
  localparam logic [31:0] RST_TARGET           = 32'h0000_0000;
  localparam logic [31:0] RST_COUNT            = 32'h0000_0000;

  // Slot timing: the time in microseconds and the derived cycle count at 100 MHz.
  localparam int unsigned SLOT_TIME_US    = 625;
  localparam int unsigned CLK_MHZ         = 100;
  localparam int unsigned SLOT_CYCLES_DEF = SLOT_TIME_US * CLK_MHZ;

  // AXI response codes.
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Bundle of test-mode settings handed to the radio datapath.
  typedef struct packed {
    logic       endlessRx;        // Receive window held open.
    logic       endlessTx;        // Payload continues without end.
    logic       prbs15;           // 1 selects the 15-bit sequence, 0 the 9-bit one.
    logic       payloadFromPrbs;  // Payload bytes come from the generator.
    logic [8:0] tx_test_length;         // Payload length in bytes actually used.
  } test_cfg_type;

  // Bundle of prefetch timing settings handed to the exchange-table fetcher.
  typedef struct packed {
    logic       abortEnable;      // Anticipated prefetch abort enabled.
    logic [9:0] abortInstant;     // Immediate-abort instant in microseconds.
    logic [8:0] fetchInstant;     // Table prefetch instant in microseconds.
  } prefetch_cfg_type;

endpackage
`default_nettype wire

// *** pkt_counter.sv ***
`timescale 1ns/1ns
`default_nettype none
// Packet counter that runs only while enabled and clears while disabled.
module pkt_counter (
  input  wire logic        mclk,     // Core clock.
  input  wire logic        sys_rst,  // Synchronous reset, active high.
  input  wire logic        ce,       // Clock enable; low freezes the count.
  input  wire logic        enable,   // Counting enabled.
  input  wire logic        inc,      // One-cycle pulse per counted packet.
  output logic      [31:0] count_r   // Running count.
);
  import rf_slot_pkg::*;

  // A disabled counter restarts at zero, so a fresh enable starts a clean run.
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      count_r <= RST_COUNT;
    end else if (ce) begin
      if (!enable) begin
        count_r <= RST_COUNT;
      end else if (inc) begin
        count_r <= count_r + 32'h0000_0001;
      end
    end
  end

endmodule // pkt_counter
`default_nettype wire

// *** rf_test_and_slot_timer_regs.sv ***
`timescale 1ns/1ns
`default_nettype none
// Operation
// - Test mode bit 31 holds receive window open.
// - Bit 27 counts received packets, reported on abort.
// - Test mode bit 15 makes payload endless.
// - Bit 14 picks descriptor or test length.
// - Bit 13 picks 9-bit or 15-bit sequence.
// - Bit 12 picks memory or generator payload.
// - Bit 11 counts sent packets, reported on abort.
// - Nine-bit test length used when selected.
// - Sent count readable, valid while enabled.
// - Received count counts only error-free packets.
// - Prefetch abort enable bit, resets to one.
// - Ten-bit abort instant, resets to 0x1FE.
// - Nine-bit table fetch instant, resets to 0x96.
// - Coarse target matches counter top, low bits zero.
// - Precise target matches whole slot counter.
// - Snapshot bit copies counter, then self-clears.
module rf_test_and_slot_timer_regs #(
  parameter int unsigned SLOT_CYCLES = rf_slot_pkg::SLOT_CYCLES_DEF  // Core cycles per 625 us slot.
) (
  input  wire logic                          mclk,            // Core clock, 100 MHz.
  input  wire logic                          sys_rst,         // Synchronous reset, active high.
  input  wire logic                          ce,              // Clock enable; low freezes all state.
  input  wire logic                   [31:0] awaddr,          // Write address.
  input  wire logic                          awvalid,         // Write address valid.
  output logic                               awready,         // Write address ready.
  input  wire logic                   [31:0] wdata,           // Write data.
  input  wire logic                   [3:0]  wstrb,           // Write byte strobes.
  input  wire logic                          wvalid,          // Write data valid.
  output logic                               wready,          // Write data ready.
  output logic                        [1:0]  bresp,           // Write response.
  output logic                               bvalid,          // Write response valid.
  input  wire logic                          bready,          // Write response ready.
  input  wire logic                   [31:0] araddr,          // Read address.
  input  wire logic                          arvalid,         // Read address valid.
  output logic                               arready,         // Read address ready.
  output logic                        [31:0] rdata,           // Read data.
  output logic                        [1:0]  rresp,           // Read response.
  output logic                               rvalid,          // Read data valid.
  input  wire logic                          rready,          // Read data ready.
  input  wire logic                          rfTestMode,      // Radio is in RF test mode.
  input  wire logic                   [8:0]  descPayloadLen,  // Descriptor payload length in bytes.
  input  wire logic                          txPacketDone,    // Pulse per transmitted packet.
  input  wire logic                          rxPacketDone,    // Pulse per received packet.
  input  wire logic                          rxSyncError,     // Sync error on the packet just done.
  input  wire logic                          rxCrcError,      // CRC error on the packet just done.
  input  wire logic                          rfAbort,         // Pulse on the RF abort command.
  output rf_slot_pkg::test_cfg_type          testCfg,         // Test settings for the datapath.
  output rf_slot_pkg::prefetch_cfg_type      prefetchCfg,     // Prefetch timing settings.
  output logic                        [31:0] structTxCount,   // Sent count for the control structure.
  output logic                        [31:0] structRxCount,   // Received count for the control structure.
  output logic                               countReport,     // Pulse: structure counts updated.
  output logic                               coarseTargetIrq, // Pulse on coarse target match.
  output logic                               preciseTargetIrq // Pulse on precise target match.
);
  import rf_slot_pkg::*;

  localparam logic [15:0] SLOT_LAST = 16'(SLOT_CYCLES - 1);  // Last divider count of a slot.

  logic [31:0] rfCtrl_r;        // rf_test_control storage.
  logic [31:0] timCtrl_r;       // timing_generator_control storage.
  logic [31:0] coarseTarget_r;  // coarse_timer_target storage.
  logic [31:0] precise_target_r;    // fine_timer_target storage.
  logic [31:0] txStatus_r;      // Reported sent count.
  logic [31:0] rxStatus_r;      // Reported received count.
  logic [26:0] snapshot_r;      // Readable slot_time_counter copy.
  logic        snapPend_r;      // Snapshot requested, not yet taken.
  logic [15:0] slotDiv_r;       // Cycle divider within a slot.
  logic [26:0] baseCnt_r;       // Running base time counter.
  logic [26:0] baseNxt;         // Base counter after the next tick.
  logic        slotTick;        // Last cycle of a slot.
  logic        awHeld_r;        // Write address captured.
  logic        wHeld_r;         // Write data captured.
  logic [31:0] wAddr_r;         // Captured write address.
  logic [31:0] wData_r;         // Captured write data.
  logic [3:0]  wStrb_r;         // Captured byte strobes.
  logic        doWrite;         // Register write takes place this cycle.
  logic        doRead;          // Read address taken this cycle.
  logic [31:0] rdMux;           // Read data selected by address.
  logic        rdHit;           // Read address is mapped.
  logic        wrHit;           // Write address is mapped.
  logic [31:0] txRunning;       // Live sent count.
  logic [31:0] rxRunning;       // Live received count.
  logic        txCountEn;       // Sent counting active.
  logic        rxCountEn;       // Received counting active.
  logic        rxGood;          // Received packet free of sync and CRC errors.

  // Applies byte strobes and keeps undefined bits at zero.
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] strb, input logic [31:0] mask);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        res[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    return res & mask;
  endfunction

  // Ready outputs are combinational; all three drop while ce is low so nothing is
  // accepted in a frozen cycle.
  assign awready = ce && !awHeld_r && !bvalid;
  assign wready  = ce && !wHeld_r && !bvalid;
  assign arready = ce && !rvalid;
  assign doWrite = ce && awHeld_r && wHeld_r && !bvalid;
  assign doRead  = arvalid && arready;

  // Address and data are captured independently, in either order.
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      awHeld_r <= 1'b0;
      wHeld_r  <= 1'b0;
      wAddr_r  <= 32'h0000_0000;
      wData_r  <= 32'h0000_0000;
      wStrb_r  <= 4'h0;
    end else if (ce) begin
      if (awvalid && awready) begin
        awHeld_r <= 1'b1;
        wAddr_r  <= awaddr;
      end else if (doWrite) begin
        awHeld_r <= 1'b0;
      end
      if (wvalid && wready) begin
        wHeld_r <= 1'b1;
        wData_r <= wdata;
        wStrb_r <= wstrb;
      end else if (doWrite) begin
        wHeld_r <= 1'b0;
      end
    end
  end

  // Write decode; unmapped addresses answer with a slave error and store nothing.
  always_comb begin
    case (wAddr_r)
      ADDR_RF_TEST_CONTROL, ADDR_RF_TEST_TX_STAT, ADDR_RF_TEST_RX_STAT, ADDR_SLOT_TIME_COUNT,
      ADDR_TIMING_GEN_CTRL, ADDR_COARSE_TARGET, ADDR_FINE_TARGET, ADDR_BASE_SNAPSHOT: wrHit = 1'b1;
      default: wrHit = 1'b0;
    endcase
  end

  // Write response is raised the cycle after the write and held until bready.
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      bvalid <= 1'b0;
      bresp  <= RESP_OKAY;
    end else if (ce) begin
      if (doWrite) begin
        bvalid <= 1'b1;
        bresp  <= wrHit ? RESP_OKAY : RESP_SLVERR;
      end else if (bready) begin
        bvalid <= 1'b0;
      end
    end
  end

  // Test control register; all defined bits are plain read/write, the rest read zero.
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      rfCtrl_r <= RST_RF_TEST_CONTROL;
    end else if (doWrite && wAddr_r == ADDR_RF_TEST_CONTROL) begin
      rfCtrl_r <= merge(rfCtrl_r, wData_r, wStrb_r, MASK_RF_TEST_CONTROL);
    end
  end

  // Timing generator control; the abort enable comes out of reset set.
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      timCtrl_r <= RST_TIMING_GEN_CTRL;
    end else if (doWrite && wAddr_r == ADDR_TIMING_GEN_CTRL) begin
      timCtrl_r <= merge(timCtrl_r, wData_r, wStrb_r, MASK_TIMING_GEN_CTRL);
    end
  end

  // Target registers for the two comparators.
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      coarseTarget_r <= RST_TARGET;
      precise_target_r   <= RST_TARGET;
    end else if (doWrite) begin
      if (wAddr_r == ADDR_COARSE_TARGET) begin
        coarseTarget_r <= merge(coarseTarget_r, wData_r, wStrb_r, MASK_COARSE_TARGET);
      end
      if (wAddr_r == ADDR_FINE_TARGET) begin
        precise_target_r <= merge(precise_target_r, wData_r, wStrb_r, MASK_FINE_TARGET);
      end
    end
  end

  // Snapshot request: a fresh request wins over the self-clear, so none is lost.
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      snapPend_r <= 1'b0;
      snapshot_r <= 27'h000_0000;
    end else if (ce) begin
      if (snapPend_r) begin
        snapshot_r <= baseCnt_r;
      end
      if (doWrite && wAddr_r == ADDR_BASE_SNAPSHOT && wStrb_r[0] && wData_r[POS_SNAPSHOT]) begin
        snapPend_r <= 1'b1;
      end else if (snapPend_r) begin
        snapPend_r <= 1'b0;
      end
    end
  end

  // Slot divider and base time counter; the 27-bit counter wraps on its own.
  assign slotTick = ce && (slotDiv_r == SLOT_LAST);
  assign baseNxt  = baseCnt_r + 27'h000_0001;
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      slotDiv_r <= 16'h0000;
      baseCnt_r <= 27'h000_0000;
    end else if (ce) begin
      slotDiv_r <= slotTick ? 16'h0000 : slotDiv_r + 16'h0001;
      if (slotTick) begin
        baseCnt_r <= baseNxt;
      end
    end
  end

  // Target comparators fire once, on the tick that reaches the matching count. The coarse
  // one only checks at multiples of 16 slots, which is where its 10 ms grain comes from.
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      coarseTargetIrq  <= 1'b0;
      preciseTargetIrq <= 1'b0;
    end else if (ce) begin
      coarseTargetIrq  <= slotTick && baseNxt[3:0] == 4'h0
                          && baseNxt[26:4] == coarseTarget_r[22:0];
      preciseTargetIrq <= slotTick && baseNxt == precise_target_r[26:0];
    end
  end

  // Packet counting only happens in test mode with the matching enable set.
  assign txCountEn = rfTestMode && rfCtrl_r[POS_TX_COUNT_EN];
  assign rxCountEn = rfTestMode && rfCtrl_r[POS_RX_COUNT_EN];
  assign rxGood    = rxPacketDone && !rxSyncError && !rxCrcError;

  pkt_counter txCounter (
    .mclk    (mclk),
    .sys_rst (sys_rst),
    .ce      (ce),
    .enable  (txCountEn),
    .inc     (txPacketDone),
    .count_r (txRunning)
  );

  pkt_counter rxCounter (
    .mclk    (mclk),
    .sys_rst (sys_rst),
    .ce      (ce),
    .enable  (rxCountEn),
    .inc     (rxGood),
    .count_r (rxRunning)
  );

  // On the abort command each enabled live count is published to status and structure.
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      txStatus_r  <= RST_COUNT;
      rxStatus_r  <= RST_COUNT;
      countReport <= 1'b0;
    end else if (ce) begin
      countReport <= rfAbort && (txCountEn || rxCountEn);
      if (rfAbort && txCountEn) begin
        txStatus_r <= txRunning;
      end
      if (rfAbort && rxCountEn) begin
        rxStatus_r <= rxRunning;
      end
    end
  end
  assign structTxCount = txStatus_r;
  assign structRxCount = rxStatus_r;

  // Settings for the datapath are registered; test-mode fields are gated by test mode.
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      testCfg     <= '0;
      prefetchCfg <= '0;
    end else if (ce) begin
      testCfg.endlessRx       <= rfTestMode && rfCtrl_r[POS_ENDLESS_RX];
      testCfg.endlessTx       <= rfTestMode && rfCtrl_r[POS_ENDLESS_TX];
      testCfg.prbs15          <= rfTestMode && rfCtrl_r[POS_PRBS_SEL];
      testCfg.payloadFromPrbs <= rfTestMode && rfCtrl_r[POS_TX_PAYLOAD_SEL];
      testCfg.tx_test_length        <= (rfTestMode && rfCtrl_r[POS_TX_LENGTH_SEL])
                                 ? rfCtrl_r[TX_LENGTH_MSB:0] : descPayloadLen;
      prefetchCfg.abortEnable  <= timCtrl_r[POS_PREFETCH_ABORT];
      prefetchCfg.abortInstant <= timCtrl_r[ABORT_INSTANT_MSB:ABORT_INSTANT_LSB];
      prefetchCfg.fetchInstant <= timCtrl_r[FETCH_INSTANT_MSB:0];
    end
  end

  // Read decode; the snapshot trigger reads back as zero.
  always_comb begin
    rdHit = 1'b1;
    case (araddr)
      ADDR_RF_TEST_CONTROL: rdMux = rfCtrl_r;
      ADDR_RF_TEST_TX_STAT: rdMux = txStatus_r;
      ADDR_RF_TEST_RX_STAT: rdMux = rxStatus_r;
      ADDR_SLOT_TIME_COUNT: rdMux = {5'h00, snapshot_r};
      ADDR_TIMING_GEN_CTRL: rdMux = timCtrl_r;
      ADDR_COARSE_TARGET:   rdMux = coarseTarget_r;
      ADDR_FINE_TARGET:     rdMux = precise_target_r;
      ADDR_BASE_SNAPSHOT:   rdMux = 32'h0000_0000;
      default: begin
        rdMux = 32'h0000_0000;
        rdHit = 1'b0;
      end
    endcase
  end

  // Read data is registered one cycle after the address and held until rready.
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      rvalid <= 1'b0;
      rdata  <= 32'h0000_0000;
      rresp  <= RESP_OKAY;
    end else if (ce) begin
      if (doRead) begin
        rvalid <= 1'b1;
        rdata  <= rdMux;
        rresp  <= rdHit ? RESP_OKAY : RESP_SLVERR;
      end else if (rready) begin
        rvalid <= 1'b0;
      end
    end
  end

  // A write that reaches a mapped address is answered OKAY on the next enabled edge.
  sequence s_write_fires;
    !sys_rst && doWrite && wrHit;
  endsequence
  sequence s_okay_answer;
    bvalid && bresp == RESP_OKAY;
  endsequence
  a_write_answer: assert property (@(posedge mclk) disable iff (sys_rst)
    s_write_fires |=> s_okay_answer) else $error("mapped write not answered OKAY");

  a_snap_copy: assert property (@(posedge mclk) disable iff (sys_rst)
    !sys_rst && snapPend_r && ce && !doWrite |=> !snapPend_r && snapshot_r == $past(baseCnt_r))
    else $error("snapshot not copied or not cleared");

  a_base_step: assert property (@(posedge mclk) disable iff (sys_rst)
    !sys_rst && slotTick |=> baseCnt_r == $past(baseNxt) && slotDiv_r == 16'h0000)
    else $error("base counter did not advance on slot end");

  a_coarse_match: assert property (@(posedge mclk) disable iff (sys_rst)
    $rose(coarseTargetIrq) |-> baseCnt_r[3:0] == 4'h0 && baseCnt_r[26:4] == $past(coarseTarget_r[22:0]))
    else $error("coarse irq without match");

  a_precise_match: assert property (@(posedge mclk) disable iff (sys_rst)
    $rose(preciseTargetIrq) |-> baseCnt_r == $past(precise_target_r[26:0]))
    else $error("precise irq without match");

  a_tx_report: assert property (@(posedge mclk) disable iff (sys_rst)
    !sys_rst && ce && rfAbort && txCountEn |=> txStatus_r == $past(txRunning) && countReport)
    else $error("sent count not reported on abort");

  a_rx_report: assert property (@(posedge mclk) disable iff (sys_rst)
    !sys_rst && ce && rfAbort && rxCountEn |=> structRxCount == $past(rxRunning))
    else $error("received count not reported on abort");

  a_length_pick: assert property (@(posedge mclk) disable iff (sys_rst)
    !sys_rst && ce |=> testCfg.tx_test_length == $past((rfTestMode && rfCtrl_r[POS_TX_LENGTH_SEL])
                                                 ? rfCtrl_r[TX_LENGTH_MSB:0] : descPayloadLen))
    else $error("payload length source wrong");

  a_endless_rx: assert property (@(posedge mclk) disable iff (sys_rst)
    !sys_rst && ce |=> testCfg.endlessRx == $past(rfTestMode && rfCtrl_r[POS_ENDLESS_RX]))
    else $error("endless receive window wrong");

endmodule // rf_test_and_slot_timer_regs
`default_nettype wire

// *** rf_test_and_slot_timer_regs_tb_top.sv ***
`timescale 1ns/1ns
`default_nettype none
module rf_test_and_slot_timer_regs_tb_top;
  import rf_slot_pkg::*;
  localparam int unsigned SLOTS = 16;  // A short slot keeps the timer waits brief.
  logic mclk = 0, sys_rst = 1, ce = 1, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic rfTestMode = 0, txPacketDone = 0, rxPacketDone = 0, rxSyncError = 0, rxCrcError = 0, rfAbort = 0;
  logic awready, wready, bvalid, arready, rvalid, countReport, coarseTargetIrq, preciseTargetIrq;
  logic [31:0] awaddr = 0, wdata = 0, araddr = 0, rdata, structTxCount, structRxCount, rdv, s;
  logic [3:0] wstrb = 0;
  logic [8:0] descPayloadLen = 0;
  logic [1:0] bresp, rresp, rsp, wrsp;
  logic [31:0] rows [7][4];  // Address, write data, expected readback, expected read response.
  int badCount = 0, checked = 0;
  test_cfg_type testCfg;
  prefetch_cfg_type prefetchCfg;
  rf_test_and_slot_timer_regs #(.SLOT_CYCLES(SLOTS)) u_dut (.mclk, .sys_rst, .ce, .awaddr, .awvalid, .awready,
    .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp,
    .rvalid, .rready, .rfTestMode, .descPayloadLen, .txPacketDone, .rxPacketDone, .rxSyncError, .rxCrcError,
    .rfAbort, .testCfg, .prefetchCfg, .structTxCount, .structRxCount, .countReport, .coarseTargetIrq,
    .preciseTargetIrq);
  // The clock toggles every half period of 5 ns.
  always #5 mclk = ~mclk;
  // Prints the counts and the verdict, then ends the run.
  task automatic results();
    $display("comparisons %0d mismatches %0d", checked, badCount);
    if (badCount == 0 && checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  // Compares one value with case equality so an unknown never matches.
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e) begin
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
      badCount++;
    end
  endtask
  // A wait that ran out of its bound is a mismatch and closes the run.
  task automatic hang(input logic ok);
    if (!ok) begin
      $display("CHECK FAILED wait expected 1 seen 0");
      badCount++;
      results();
    end
  endtask
  // One AXI write; each channel is released at the edge that takes it.
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    int n;
    awaddr <= a; wdata <= d; wstrb <= 4'hF; awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge mclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (bvalid === 1'b1) break;
    end
    hang(n < 50); wrsp = bresp; bready <= 1'b0;
    @(posedge mclk);
  endtask
  // One AXI read; data and response are taken at the edge that shows rvalid.
  task automatic rd(input logic [31:0] a);
    int n;
    araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge mclk);
      if (arready) arvalid <= 1'b0;
      if (rvalid === 1'b1) break;
    end
    hang(n < 50); rdv = rdata; rsp = rresp; rready <= 1'b0;
    @(posedge mclk);
  endtask
  // Waits a bounded time for one of the two target pulses.
  task automatic waitIrq(input logic fine);
    int n;
    for (n = 0; n < 1000; n++) begin
      @(posedge mclk);
      if ((fine ? preciseTargetIrq : coarseTargetIrq) === 1'b1) break;
    end
    hang(n < 1000);
  endtask
  // Triggers a copy of the base counter and reads the copy back.
  task automatic snap();
    wr(ADDR_BASE_SNAPSHOT, 32'h1);
    rd(ADDR_SLOT_TIME_COUNT);
  endtask
  // Main sequence: reset values, register table, test-mode counts, timer targets, frozen cycles, then a mid-run reset.
  initial begin
    rows = '{'{ADDR_RF_TEST_CONTROL, 32'hFFFF_FFFF, MASK_RF_TEST_CONTROL, 0},
      '{ADDR_TIMING_GEN_CTRL, 32'hFFFF_FFFF, MASK_TIMING_GEN_CTRL, 0},
      '{ADDR_COARSE_TARGET, 32'hFFFF_FFFF, MASK_COARSE_TARGET, 0},
      '{ADDR_FINE_TARGET, 32'hFFFF_FFFF, MASK_FINE_TARGET, 0},
      '{ADDR_BASE_SNAPSHOT, 32'hFFFF_FFFF, 0, 0},
      '{ADDR_RF_TEST_TX_STAT, 32'hFFFF_FFFF, 0, 0},
      '{32'h4000_0100, 32'hFFFF_FFFF, 0, 2}};
    repeat (2) @(posedge mclk);
    sys_rst <= 1'b0;
    @(posedge mclk);
    rd(ADDR_RF_TEST_CONTROL); chk("rf_test_control reset", RST_RF_TEST_CONTROL, rdv);
    rd(ADDR_TIMING_GEN_CTRL); chk("timing reset", RST_TIMING_GEN_CTRL, rdv);
    chk("prefetchCfg", {1'b1, 10'h1FE, 9'h096}, prefetchCfg);
    foreach (rows[i]) begin
      wr(rows[i][0], rows[i][1]); rd(rows[i][0]);
      chk("rdata", rows[i][2], rdv);
      chk("rresp", rows[i][3], {30'h0, rsp});
    end
    chk("bresp unmapped", 32'h2, {30'h0, wrsp});
    wr(ADDR_RF_TEST_CONTROL, 32'h8800_F805); rfTestMode <= 1'b1;
    repeat (2) @(posedge mclk);
    chk("testCfg on", 13'h1E05, testCfg);
    // Two sent packets; four received of which one has a sync and one a CRC error.
    txPacketDone <= 1'b1; rxPacketDone <= 1'b1; @(posedge mclk);
    rxSyncError <= 1'b1; @(posedge mclk);
    txPacketDone <= 1'b0; rxSyncError <= 1'b0; rxCrcError <= 1'b1; @(posedge mclk);
    rxCrcError <= 1'b0; @(posedge mclk);
    rxPacketDone <= 1'b0; rfAbort <= 1'b1; @(posedge mclk);
    rfAbort <= 1'b0; #1;
    // The report pulse stands only in the cycle after the abort edge.
    chk("countReport", 1, countReport);
    chk("structTxCount", 2, structTxCount);
    chk("structRxCount", 2, structRxCount);
    @(posedge mclk); #1;
    chk("countReport end", 0, countReport);
    @(posedge mclk);
    rd(ADDR_RF_TEST_TX_STAT); chk("tx status", 2, rdv);
    rd(ADDR_RF_TEST_RX_STAT); chk("rx status", 2, rdv);
    rfTestMode <= 1'b0; descPayloadLen <= 9'h0AB;
    repeat (2) @(posedge mclk);
    chk("testCfg off", 13'h00AB, testCfg);
    snap(); s = rdv;
    wr(ADDR_FINE_TARGET, s + 8); wr(ADDR_COARSE_TARGET, (s >> 4) + 2);
    waitIrq(1'b1); snap(); chk("fine match", s + 8, rdv);
    waitIrq(1'b0); snap(); chk("coarse match", ((s >> 4) + 2) << 4, rdv);
    // Frozen cycles: the readies drop and the registered settings keep their value.
    ce <= 1'b0; descPayloadLen <= 9'h055;
    repeat (2) @(posedge mclk); #1;
    chk("ready frozen", 0, {awready, wready, arready});
    chk("testCfg frozen", 13'h00AB, testCfg);
    @(posedge mclk);
    ce <= 1'b1;
    repeat (2) @(posedge mclk);
    chk("testCfg thawed", 13'h0055, testCfg);
    // A reset in mid-run brings back the reset values and clears the reported counts.
    sys_rst <= 1'b1; @(posedge mclk);
    sys_rst <= 1'b0; @(posedge mclk); #1;
    chk("structTxCount reset", 0, structTxCount);
    chk("structRxCount reset", 0, structRxCount);
    @(posedge mclk);
    rd(ADDR_TIMING_GEN_CTRL); chk("timing re-reset", RST_TIMING_GEN_CTRL, rdv);
    rd(ADDR_FINE_TARGET); chk("fine target re-reset", RST_TARGET, rdv);
    results();
  end
endmodule  // rf_test_and_slot_timer_regs_tb_top
`default_nettype wire
